// file: rtl/spmsp_top.v
// Function
// R1 - master drives sck with rate, idle level and phase from configuration
// R2 - master data write loads shift register, sends on mosi msb first
// R3 - slave data write loads shift register, presents on miso msb first
// R4 - slave shifts only on clock edges received from the master
// R5 - byte end sets transfer-complete flag; interrupt when enabled
// R6 - master clears flag by status access then data read
// R7 - slave clears flag by status access then data read or write
// R8 - data writes ignored while flag set until status register read
// R9 - slave software clears flag before a second byte completes
// R10 - port enable cleared by reset and by select low in master
// R11 - master select cleared by select low; sets pin directions
// R12 - interrupt enable gates complete, fault and overrun onto interrupt
// R13 - polarity bit sets sck idle level in both modes
// R14 - phase 0 captures on first transition, phase 1 on second
// R15 - master rate is clk divided by 4 to 128; slave ignores it
// R16 - upper rate bit reset to 0; 0 adds a divide-by-2 stage
// R17 - master bits hold only while select high; soft select or pin
// R18 - slave select held low per byte or continuously per phase
// R19 - software writes status register before setting master bits
// R20 - master and slave use identical polarity and phase
// R21 - disable port before changing polarity at byte boundary
// R22 - slave sck no faster than half the clk rate; the synchroniser tracks clk/4 at most
// R23 - byte completing with flag set sets overrun, keeps old data
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "spmsp_defs.vh"
module spmsp_top (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [3:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg irq_o,
  input wire sck_i,
  output reg sck_o,
  output reg sck_oe_o,
  input wire mosi_i,
  output reg mosi_o,
  output reg mosi_oe_o,
  input wire miso_i,
  output reg miso_o,
  output reg miso_oe_o,
  input wire ss_n_i
);
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  reg [7:0] serial_port_control;
  reg soft_select_manage;
  reg soft_select_level;
  reg transfer_complete_flag;
  reg overrun_flag;
  reg master_fault_flag;
  reg flag_seen_r;
  reg csr_read_r;
  reg fault_seen_r;
  reg [7:0] serial_port_data_reg;
  reg [7:0] shift_r;
  reg [2:0] bits_r;
  reg state_r;
  reg [5:0] half_cnt_r;
  reg [3:0] edge_r;
  reg sck_q_r;

  wire sck_s;
  wire mosi_s;
  wire miso_s;
  wire ss_n_s;

  spmsp_sync #(.RST_VAL(1'b0)) u_sync_sck (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .pin_i(sck_i), .level_o(sck_s));
  spmsp_sync #(.RST_VAL(1'b0)) u_sync_mosi (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .pin_i(mosi_i), .level_o(mosi_s));
  spmsp_sync #(.RST_VAL(1'b0)) u_sync_miso (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .pin_i(miso_i), .level_o(miso_s));
  spmsp_sync #(.RST_VAL(1'b1)) u_sync_ss (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .pin_i(ss_n_i), .level_o(ss_n_s));

  wire serial_irq_enable = serial_port_control[`SPMSP_C_IE];
  wire port_enable_bit = serial_port_control[`SPMSP_C_PE];
  wire rate_select_high = serial_port_control[`SPMSP_C_RH];
  wire master_select_bit = serial_port_control[`SPMSP_C_MS];
  wire clock_polarity_bit = serial_port_control[`SPMSP_C_POL];
  wire clock_phase_bit = serial_port_control[`SPMSP_C_PHA];
  wire [1:0] rate_select_low = serial_port_control[`SPMSP_C_RL_HI:`SPMSP_C_RL_LO];

  wire is_master = port_enable_bit & master_select_bit;
  wire is_slave = port_enable_bit & ~master_select_bit;
  // soft management replaces the pin with the programmed level
  wire ss_n_eff = soft_select_manage ? soft_select_level : ss_n_s; // R17
  wire mode_fault = is_master & ~ss_n_eff; // R10 R11 R17
  wire slave_sel = is_slave & ~ss_n_eff;

  // bus decode: one access per request, answered on the next edge
  wire bus_acc = cyc_i & stb_i & ~ack_o;
  wire [1:0] bus_idx = adr_i[3:2];
  wire acc_ctrl = bus_acc & (bus_idx == `SPMSP_IDX_CTRL);
  wire acc_csr = bus_acc & (bus_idx == `SPMSP_IDX_CSR);
  wire acc_data = bus_acc & (bus_idx == `SPMSP_IDX_DATA);
  wire wr_lane = we_i & sel_i[0];

  // half-period selection for the master clock
  reg [5:0] half_base;
  always @* begin
    case (rate_select_low)
      2'h0: half_base = `SPMSP_HALF_00;
      2'h1: half_base = `SPMSP_HALF_01;
      2'h2: half_base = `SPMSP_HALF_10;
      2'h3: half_base = `SPMSP_HALF_11;
      default: half_base = `SPMSP_HALF_00;
    endcase
  end
  // upper rate bit at 0 keeps the extra divide-by-2 stage in the path
  // the slowest rate needs 64 clocks per half period, one bit more than the counter
  wire [6:0] half_len = rate_select_high ? {1'b0, half_base} : {half_base, 1'b0}; // R15 R16
  wire [6:0] half_m1 = half_len - 7'h01;

  // master edge generator
  wire m_tick = is_master & (state_r == ST_RUN) & (half_cnt_r == 6'h00);
  // even edges are leading transitions; phase picks which of them capture
  wire m_smp = m_tick & (edge_r[0] == clock_phase_bit); // R14
  wire m_lch = m_tick & (edge_r[0] != clock_phase_bit);
  wire m_done = m_tick & (edge_r == `SPMSP_LAST_EDGE);

  // slave edge detect on the synchronised clock
  wire s_edge = slave_sel & (sck_s != sck_q_r); // R4
  wire s_lead = (sck_q_r == clock_polarity_bit); // R13
  wire s_smp = s_edge & (s_lead ^ clock_phase_bit); // R14
  wire s_lch = s_edge & ~(s_lead ^ clock_phase_bit);

  wire smp = m_smp | s_smp;
  wire lch = m_lch | s_lch;
  wire din = is_master ? miso_s : mosi_s;
  wire [7:0] rx_next = smp ? {shift_r[6:0], din} : shift_r;
  wire s_done = s_smp & (bits_r == `SPMSP_LAST_BIT);
  wire xfer_done = m_done | s_done; // R5

  wire busy = (state_r == ST_RUN) | (bits_r != 3'h0);
  // a write is dropped while the flag is up and the status was not read yet
  wire wr_block = transfer_complete_flag & ~csr_read_r; // R8
  wire data_load = acc_data & wr_lane & ~wr_block & ~busy & port_enable_bit;
  wire data_rd = acc_data & ~we_i;
  wire data_wr = acc_data & wr_lane;
  wire tcf_clear = flag_seen_r & (data_rd | (data_wr & is_slave)); // R6 R7

  // bus answer
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_o <= bus_acc;
      if (bus_acc) begin
        dat_o <= 32'h0000_0000;
        if (~we_i) begin
          case (bus_idx)
            `SPMSP_IDX_CTRL: dat_o[7:0] <= serial_port_control;
            `SPMSP_IDX_CSR: begin
              dat_o[`SPMSP_S_TCF] <= transfer_complete_flag;
              dat_o[`SPMSP_S_OVR] <= overrun_flag;
              dat_o[`SPMSP_S_MASTER_FAULT_FLAG] <= master_fault_flag;
              dat_o[`SPMSP_S_BUSY] <= busy;
              dat_o[`SPMSP_S_SSM] <= soft_select_manage;
              dat_o[`SPMSP_S_SSI] <= soft_select_level;
            end
            `SPMSP_IDX_DATA: dat_o[7:0] <= serial_port_data_reg;
            default: dat_o <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // configuration registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      serial_port_control <= `SPMSP_CTRL_RST; // R10 R16
      soft_select_manage <= 1'b0;
      soft_select_level <= 1'b0;
    end else if (ce_i) begin
      if (acc_ctrl & wr_lane) begin
        serial_port_control <= dat_i[7:0];
      end
      if (acc_csr & wr_lane) begin
        soft_select_manage <= dat_i[`SPMSP_S_SSM];
        soft_select_level <= dat_i[`SPMSP_S_SSI];
      end
      // hardware clear beats a software write in the same cycle
      if (mode_fault) begin
        serial_port_control[`SPMSP_C_PE] <= 1'b0; // R10
        serial_port_control[`SPMSP_C_MS] <= 1'b0; // R11
      end
    end
  end

  // status flags; a hardware set always wins over a software clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      transfer_complete_flag <= 1'b0;
      overrun_flag <= 1'b0;
      master_fault_flag <= 1'b0;
      flag_seen_r <= 1'b0;
      csr_read_r <= 1'b0;
      fault_seen_r <= 1'b0;
      serial_port_data_reg <= `SPMSP_BYTE_RST;
    end else if (ce_i) begin
      if (acc_csr & (transfer_complete_flag | overrun_flag)) begin
        flag_seen_r <= 1'b1;
      end
      if (acc_csr & ~we_i & transfer_complete_flag) begin
        csr_read_r <= 1'b1;
      end
      if (acc_csr & master_fault_flag) begin
        fault_seen_r <= 1'b1;
      end
      if (tcf_clear) begin
        transfer_complete_flag <= 1'b0; // R6 R7
        flag_seen_r <= 1'b0;
        csr_read_r <= 1'b0;
      end
      if (flag_seen_r & data_rd) begin
        overrun_flag <= 1'b0;
      end
      if (fault_seen_r & acc_ctrl & wr_lane) begin
        master_fault_flag <= 1'b0;
        fault_seen_r <= 1'b0;
      end
      if (mode_fault) begin
        master_fault_flag <= 1'b1;
      end
      if (xfer_done) begin
        if (transfer_complete_flag & ~tcf_clear) begin
          overrun_flag <= 1'b1; // R23
        end else begin
          serial_port_data_reg <= rx_next;
        end
        transfer_complete_flag <= 1'b1; // R5
      end
    end
  end

  // master clock sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      half_cnt_r <= 6'h00;
      edge_r <= 4'h0;
      sck_o <= 1'b0;
    end else if (ce_i) begin
      case (state_r)
        ST_IDLE: begin
          sck_o <= clock_polarity_bit; // R13
          edge_r <= 4'h0;
          if (data_load & is_master) begin
            state_r <= ST_RUN; // R2
            half_cnt_r <= half_m1[5:0];
          end
        end
        ST_RUN: begin
          if (~is_master) begin
            state_r <= ST_IDLE;
          end else if (half_cnt_r == 6'h00) begin
            half_cnt_r <= half_m1[5:0]; // R15
            sck_o <= ~sck_o; // R1
            edge_r <= edge_r + 4'h1;
            if (m_done) begin
              state_r <= ST_IDLE;
            end
          end else begin
            half_cnt_r <= half_cnt_r - 6'h01;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // shared shift path; the same bit register feeds mosi or miso
  always @(posedge clk_i) begin
    if (rst_i) begin
      shift_r <= `SPMSP_BYTE_RST;
      bits_r <= 3'h0;
      mosi_o <= 1'b0;
      miso_o <= 1'b0;
      sck_q_r <= 1'b0;
    end else if (ce_i) begin
      sck_q_r <= sck_s;
      if (data_load) begin
        shift_r <= dat_i[7:0]; // R2 R3
        mosi_o <= dat_i[7];
        miso_o <= dat_i[7];
        bits_r <= 3'h0;
      end else begin
        if (smp) begin
          shift_r <= rx_next;
          bits_r <= bits_r + 3'h1;
        end
        if (lch) begin
          mosi_o <= shift_r[7];
          miso_o <= shift_r[7];
        end
        // deselect ends a partial byte so the next one starts at msb
        if (is_slave & ss_n_eff) begin
          bits_r <= 3'h0; // R18
        end
        if (~port_enable_bit) begin
          bits_r <= 3'h0;
        end
      end
    end
  end

  // pin directions and interrupt
  always @(posedge clk_i) begin
    if (rst_i) begin
      sck_oe_o <= 1'b0;
      mosi_oe_o <= 1'b0;
      miso_oe_o <= 1'b0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      sck_oe_o <= is_master; // R1 R11
      mosi_oe_o <= is_master; // R11
      miso_oe_o <= slave_sel; // R3
      irq_o <= serial_irq_enable & (transfer_complete_flag | overrun_flag
        | master_fault_flag); // R5 R12
    end
  end
endmodule // spmsp_top

// file: rtl/spmsp_defs.vh
`ifndef SPMSP_DEFS_VH
`define SPMSP_DEFS_VH

// register word indices, decoded from adr_i[3:2]
`define SPMSP_IDX_CTRL 2'h0
`define SPMSP_IDX_CSR 2'h1
`define SPMSP_IDX_DATA 2'h2

// reset values
`define SPMSP_CTRL_RST 8'h00
`define SPMSP_SEL_RST 2'h0
`define SPMSP_BYTE_RST 8'h00

// control register fields
`define SPMSP_C_IE 7
`define SPMSP_C_PE 6
`define SPMSP_C_RH 5
`define SPMSP_C_MS 4
`define SPMSP_C_POL 3
`define SPMSP_C_PHA 2
`define SPMSP_C_RL_HI 1
`define SPMSP_C_RL_LO 0

// control/status register fields
`define SPMSP_S_TCF 7
`define SPMSP_S_OVR 5
`define SPMSP_S_MASTER_FAULT_FLAG 4
`define SPMSP_S_BUSY 3
`define SPMSP_S_SSM 1
`define SPMSP_S_SSI 0

// sck half periods in clk cycles with the divide-by-2 stage bypassed
`define SPMSP_HALF_00 6'h02
`define SPMSP_HALF_01 6'h04
`define SPMSP_HALF_10 6'h10
`define SPMSP_HALF_11 6'h20

// byte framing
`define SPMSP_LAST_EDGE 4'hf
`define SPMSP_LAST_BIT 3'h7

`endif

// file: rtl/spmsp_sync.v
`timescale 1ns/100ps
// three-stage pin synchroniser; output follows once stages two and three agree
module spmsp_sync #(
  parameter RST_VAL = 1'b0
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire pin_i,
  output reg level_o
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      level_o <= RST_VAL;
    end else if (ce_i) begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_o <= s3_r;
      end
    end
  end
endmodule // spmsp_sync

// file: tb/spmsp_chk.sv
`timescale 1ns/100ps
module spmsp_chk (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire cyc_i,
  input wire stb_i,
  input wire ack_o,
  input wire irq_o,
  input wire sck_o,
  input wire sck_oe_o,
  input wire mosi_oe_o,
  input wire miso_oe_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_take;
    cyc_i && stb_i && !ack_o && ce_i;
  endsequence
  sequence s_tog;
    sck_oe_o && $past(sck_oe_o) && $changed(sck_o);
  endsequence
  property p_ack;
    s_take |=> ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_hold;
    ack_o |-> $past(stb_i);
  endproperty
  a_hold: assert property (p_hold) else $error("ack without request");
  // reset must be seen even though the other checks are masked by it
  property p_rst;
    disable iff (1'b0) rst_i && ce_i |=> !ack_o && !irq_o && !sck_oe_o && !miso_oe_o;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs live after reset");
  property p_oe;
    sck_oe_o == mosi_oe_o;
  endproperty
  a_oe: assert property (p_oe) else $error("master pins split");
  property p_excl;
    miso_oe_o |-> !sck_oe_o;
  endproperty
  a_excl: assert property (p_excl) else $error("pin directions clash");
  property p_step;
    s_tog |=> $stable(sck_o);
  endproperty
  a_step: assert property (p_step) else $error("sck faster than clk/4");
  property p_irqf;
    $fell(irq_o) |-> ack_o || $past(ack_o) || $past(ack_o, 2);
  endproperty
  a_irqf: assert property (p_irqf) else $error("irq dropped without access");
endmodule  // spmsp_chk

bind spmsp_top spmsp_chk u_spmsp_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .irq_o(irq_o), .sck_o(sck_o),
  .sck_oe_o(sck_oe_o), .mosi_oe_o(mosi_oe_o), .miso_oe_o(miso_oe_o));

// file: tb/spmsp_peer.sv
`timescale 1ns/100ps
module spmsp_peer (
  input wire sck_i,
  input wire mosi_i,
  input wire sel_n_i,
  input wire pol_i,
  input wire pha_i,
  input wire [7:0] tx_i,
  output logic miso_o,
  output logic [7:0] rx_o
);
  logic [7:0] sh;
  initial miso_o = 1'b0;
  // a released line flips so a stale bit never passes for data
  always @(sel_n_i) begin
    if (sel_n_i) miso_o = ~miso_o;
    else begin
      sh = tx_i;
      miso_o = tx_i[7];
    end
  end
  always @(sck_i) begin
    if (!sel_n_i) begin
      if (sck_i ^ pol_i ^ pha_i) rx_o = {rx_o[6:0], mosi_i};
      else if (pha_i) begin
        miso_o = sh[7];
        sh = sh << 1;
      end else begin
        sh = sh << 1;
        miso_o = sh[7];
      end
    end
  end
endmodule  // spmsp_peer

// file: tb/tb.sv
`timescale 1ns/100ps
module tb;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, sck_m = 0, mosi_m = 0;
  logic ss_n_i = 1, psel_n = 1, pol = 0, pha = 0, ce = 1;
  logic [3:0] adr_i = 4'h0;
  logic [31:0] dat_i = 32'h0, rnd = 32'hc5d8;
  logic [7:0] ptx = 8'h00, q, r, d;
  wire [31:0] dat_o;
  wire ack_o, irq_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, pmiso;
  wire [7:0] prx;
  wire sck_w = sck_oe_o ? sck_o : sck_m;
  wire mosi_w = mosi_oe_o ? mosi_o : mosi_m;
  wire miso_w = miso_oe_o ? miso_o : pmiso;
  int err_count = 0, samples_checked = 0, tg, bad;
  initial forever #12.5 clk_i = ~clk_i;
  spmsp_top u_spmsp_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .irq_o(irq_o), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
    .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_i(miso_w),
    .miso_o(miso_o), .miso_oe_o(miso_oe_o), .ss_n_i(ss_n_i));
  spmsp_peer u_spmsp_peer (.sck_i(sck_w), .mosi_i(mosi_w), .sel_n_i(psel_n), .pol_i(pol),
    .pha_i(pha), .tx_i(ptx), .miso_o(pmiso), .rx_o(prx));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // half sck period in clocks, indexed by {rate_high, rate_low}
  function automatic int half(input logic [2:0] k);
    int t[8] = '{4, 8, 32, 64, 2, 4, 16, 32};
    return t[k];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] v);
    int t = 0;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, v};
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 64);
    q = dat_o[7:0];
    cyc_i <= 0;
    stb_i <= 0;
    if (t >= 64) err_count++;
  endtask
  task automatic watch(input int n, input int h);
    int g = 0;
    logic p;
    p = sck_o;
    tg = 0;
    bad = 0;
    repeat (n) begin
      @(posedge clk_i);
      g++;
      if (sck_o !== p) begin
        tg++;
        if (tg > 1 && g != h) bad++;
        g = 0;
        p = sck_o;
      end
    end
  endtask
  // bench as master at clk/16, well under the slave limit
  task automatic sb(input logic [7:0] b);
    ss_n_i <= 0;
    for (int k = 7; k >= 0; k--) begin
      mosi_m <= b[k];
      repeat (8) @(posedge clk_i);
      r[k] = miso_w;
      sck_m <= 1;
      repeat (8) @(posedge clk_i);
      sck_m <= 0;
    end
    repeat (8) @(posedge clk_i);
    ss_n_i <= 1;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    err_count++;
    test_done;
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 4'h0, 0);
    chk(q, 8'h00);
    wb(0, 4'hc, 0);
    chk(q, 8'h00);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      pol = i[0];
      pha = i[1];
      d = rnd[7:0];
      ptx <= rnd[15:8];
      wb(1, 4'h0, 8'h00);
      wb(1, 4'h4, 8'h03);
      wb(1, 4'h0, {i[2], 1'b1, i[2], 1'b1, i[0], i[1], i[1], i[0]});
      repeat (2) @(posedge clk_i);
      chk(sck_o, i[0]);
      psel_n <= 0;
      wb(1, 4'h8, d);
      watch(16 * half(i[2:0]) + 8, half(i[2:0]));
      chk(tg, 16);
      chk(bad, 0);
      chk(sck_o, i[0]);
      chk(irq_o, i[2]);
      wb(1, 4'h8, ~d);
      watch(4 * half(i[2:0]), 1);
      chk(tg, 0);
      wb(0, 4'h8, 0);
      repeat (2) @(posedge clk_i);
      chk(irq_o, i[2]);
      wb(0, 4'h4, 0);
      chk(q[7], 1'b1);
      wb(0, 4'h8, 0);
      if (half(i[2:0]) >= 8) chk(q, rnd[15:8]);
      chk(prx, d);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b0);
      psel_n <= 1;
    end
    $display("test master done");
    pol = 0;
    pha = 0;
    wb(1, 4'h0, 8'h00);
    wb(1, 4'h4, 8'h00);
    wb(1, 4'h0, 8'hc0);
    rnd = lfsr(rnd);
    wb(1, 4'h8, rnd[7:0]);
    sb(rnd[15:8]);
    chk(r, rnd[7:0]);
    chk(irq_o, 1'b1);
    wb(0, 4'h4, 0);
    chk(q & 8'ha0, 8'h80);
    wb(1, 4'h8, rnd[23:16]);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
    wb(0, 4'h8, 0);
    chk(q, rnd[15:8]);
    sb(rnd[31:24]);
    chk(r, rnd[23:16]);
    sb(8'h5a);
    wb(0, 4'h4, 0);
    chk(q & 8'ha0, 8'ha0);
    wb(0, 4'h8, 0);
    chk(q, rnd[31:24]);
    // flag cleared while the next byte is already shifting: no overrun
    sb(8'h3c);
    fork
      sb(8'ha5);
      begin
        repeat (40) @(posedge clk_i);
        wb(0, 4'h4, 0);
        wb(0, 4'h8, 0);
        chk(q, 8'h3c);
      end
    join
    wb(0, 4'h4, 0);
    chk(q & 8'ha0, 8'h80);
    wb(0, 4'h8, 0);
    chk(q, 8'ha5);
    $display("test slave done");
    wb(1, 4'h0, 8'h00);
    wb(1, 4'h0, 8'h50);
    // clock enable low freezes the select synchroniser and the mode bits
    ce <= 0;
    ss_n_i <= 0;
    repeat (8) @(posedge clk_i);
    chk(sck_oe_o, 1'b1);
    ce <= 1;
    repeat (8) @(posedge clk_i);
    chk(sck_oe_o, 1'b0);
    wb(0, 4'h0, 0);
    chk(q & 8'h50, 8'h00);
    ss_n_i <= 1;
    $display("test fault done");
    test_done;
  end
endmodule  // tb
